//--- rtl/slb_pkg.sv
// Shared constants for the segment LCD blink and timebase block
package slb_pkg;

  // ****************************************************************
  // Clock rates and glass geometry
  // ****************************************************************
  localparam int unsigned PCLK_HZ    = 200_000_000;  // Bus and core clock rate
  localparam int unsigned TB_HZ      = 32_768;       // LCD timebase target rate
  localparam int unsigned FRAME_HZ   = 64;           // Glass drive frequency
  localparam int unsigned BP_COUNT   = 4;            // Backplanes, 1/4 duty
  localparam int unsigned FP_COUNT   = 40;           // Frontplanes on the glass
  localparam int unsigned SEG_BYTES  = FP_COUNT / 2; // Two frontplanes per byte

  // ****************************************************************
  // Timebase derivation
  // ****************************************************************
  // Internal path: fractional accumulator, exact on average
  localparam logic [27:0] ACC_STEP = 28'(TB_HZ);
  localparam logic [27:0] ACC_WRAP = 28'(PCLK_HZ);
  // Spacing of internal timebase ticks in pclk cycles
  localparam int unsigned INT_TICK_MIN = PCLK_HZ / TB_HZ;
  localparam int unsigned INT_TICK_MAX = INT_TICK_MIN + 1;
  // Timebase ticks per backplane phase (128 for 64 Hz at 1/4 duty)
  localparam int unsigned TB_PER_PHASE = TB_HZ / (FRAME_HZ * BP_COUNT);
  localparam logic [6:0]  PHASE_LAST   = 7'(TB_PER_PHASE - 1);
  // Blink counter: rate code r toggles the phase every 2^(11+r) ticks
  localparam int unsigned BLINK_CNT_W    = 20;
  localparam int unsigned BLINK_BASE_BIT = 11;

  // ****************************************************************
  // Register indices (byte address = 4 * index)
  // ****************************************************************
  localparam logic [13:0] LCD_CMD_IDX    = 14'h1840;
  localparam logic [13:0] BLINK_CTRL_IDX = 14'h1841;
  localparam logic [13:0] CLK_CTRL_IDX   = 14'h1842;
  localparam logic [13:0] SEG_BASE_IDX   = 14'h1848;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CMD_SEL_BIT     = 0;  // segment_memory_select
  localparam int unsigned CMD_DISP_EN_BIT = 1;  // Display drive enable
  localparam int unsigned CMD_PHASE_BIT   = 4;  // Read only: blink on phase
  localparam int unsigned CMD_BP_LSB      = 5;  // Read only: backplane, 2 bits
  localparam int unsigned CMD_STOP_BIT    = 8;  // Read only: deep_stop_mode
  localparam int unsigned BLK_EN_BIT      = 0;  // Blink enable
  localparam int unsigned BLK_WHOLE_BIT   = 1;  // whole_display_blink
  localparam int unsigned BLK_RATE_LSB    = 2;  // Blink rate code, 3 bits
  localparam int unsigned CLK_SRC_BIT     = 0;  // 1 selects the external source
  localparam int unsigned CLK_CP_LSB      = 2;  // Charge pump rate code, 2 bits
  localparam int unsigned CLK_DIV_LSB     = 16; // External divisor minus one

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic        RST_SEL     = 1'b0;
  localparam logic        RST_DISP_EN = 1'b0;
  localparam logic        RST_BLK_EN  = 1'b0;
  localparam logic        RST_WHOLE   = 1'b0;
  localparam logic [2:0]  RST_RATE    = 3'h0;
  localparam logic        RST_SRC_EXT = 1'b0;
  localparam logic [1:0]  RST_CP_RATE = 2'h0;
  localparam logic [15:0] RST_EXT_DIV = 16'h0000;

endpackage : slb_pkg

//--- rtl/slb_timebase.sv
// Timebase generator: internal or external source divided to 32.768 kHz
`timescale 1ns/1ps

module slb_timebase
  import slb_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Source selection
  input  wire logic        src_ext,
  input  wire logic [15:0] ext_div,
  input  wire logic        ext_clk_src,
  // Timebase enable pulse
  output logic             tb_tick
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [27:0] acc;      // Fractional accumulator, internal path
    logic        ext_prev; // Last sample of the external source
    logic [15:0] ext_cnt;  // Rising edges seen in this division
    logic        tick;     // Registered timebase pulse
  } slb_tb_state_type;

  slb_tb_state_type q;
  slb_tb_state_type d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Divide either source down to the timebase rate
  always_comb
  begin
    d          = q;
    d.tick     = 1'b0;
    d.ext_prev = ext_clk_src;
    if (src_ext)
    begin
      // External source: one tick per ext_div+1 rising edges
      if (ext_clk_src && !q.ext_prev)
      begin
        if (q.ext_cnt >= ext_div)
        begin
          d.ext_cnt = 16'h0000;
          d.tick    = 1'b1;
        end
        else
        begin
          d.ext_cnt = q.ext_cnt + 16'h0001;
        end
      end
    end
    else if (q.acc + ACC_STEP >= ACC_WRAP)
    begin
      // Internal reference: carry out of the accumulator
      d.acc  = q.acc + ACC_STEP - ACC_WRAP;
      d.tick = 1'b1;
    end
    else
    begin
      d.acc = q.acc + ACC_STEP;
    end
  end

  // Register the state; no gating by any low power input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tb_tick = q.tick;

endmodule : slb_timebase

//--- rtl/slb_lcd_top.sv
// Segment LCD blink, timebase and scan control with an APB register port
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - Timebase is 32.768 kHz from either source
// - Frame, blink, pump all paced by timebase
// - Blink whole display or selected segments
// - Several blink rates, divided from timebase
// - Blinking and timebase run in deep stop
// - Select clear: memory sets segment display
// - Select set: memory reaches blink-enable plane
// - Whole blink plus select blinks every segment
// - Drive at 1/4 duty, 64 Hz
// - Four backplanes by forty frontplanes
// - Display bit 1 shows, 0 blanks
// - Byte holds two frontplanes, even low nibble
module slb_lcd_top
  import slb_pkg::*;
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [15:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Clock source and power state
  input  wire logic                  ext_clk_src,
  input  wire logic                  deep_stop_mode,
  // Glass drive
  output logic      [slb_pkg::BP_COUNT-1:0] backplane_drive,
  output logic      [slb_pkg::FP_COUNT-1:0] frontplane_drive,
  output logic                       frame_start,
  output logic                       charge_pump_tick,
  output logic                       blink_phase_on
);

  import slb_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [SEG_BYTES-1:0][7:0] disp;     // Display on/off plane
    logic [SEG_BYTES-1:0][7:0] blink;    // Blink enable plane
    logic                      sel;      // segment_memory_select
    logic                      disp_en;  // Display drive enable
    logic                      blk_en;   // Blinking enable
    logic                      whole;    // whole_display_blink
    logic [2:0]                rate;     // Blink rate code
    logic                      src_ext;  // External timebase source
    logic [1:0]                cp_rate;  // Charge pump rate code
    logic [15:0]               ext_div;  // External divisor minus one
    logic [6:0]                phase;    // Timebase ticks in this phase
    logic [1:0]                bp;       // Active backplane
    logic [BLINK_CNT_W-1:0]    bcnt;     // Blink divider
    logic [3:0]                cpcnt;    // Charge pump divider
    logic [FP_COUNT-1:0]       fp;       // Registered frontplane levels
    logic                      fstart;   // Frame start pulse
    logic                      cptick;   // Charge pump pulse
    logic [31:0]               rdata;    // Read data captured in setup
  } slb_state_type;

  slb_state_type q;
  slb_state_type d;

  // ****************************************************************
  // Timebase
  // ****************************************************************
  logic tb_tick; // One pclk pulse per timebase period

  // Runs regardless of deep_stop_mode so blinking carries on
  slb_timebase u_timebase (
    .pclk        (pclk),
    .presetn     (presetn),
    .src_ext     (q.src_ext),
    .ext_div     (q.ext_div),
    .ext_clk_src (ext_clk_src),
    .tb_tick     (tb_tick)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [13:0] word_idx; // Word index of the access
  logic [13:0] seg_rel;  // Offset into segment_memory
  logic [4:0]  seg_byte; // Byte of segment_memory
  logic        seg_hit;  // Access falls on segment_memory
  logic        reg_hit;  // Access falls on any register
  logic        wr_acc;   // Write in its access phase

  assign word_idx = paddr[15:2];
  assign seg_rel  = word_idx - SEG_BASE_IDX;
  assign seg_byte = seg_rel[4:0];
  assign seg_hit  = (word_idx >= SEG_BASE_IDX) && (seg_rel < 14'(SEG_BYTES));
  assign reg_hit  = seg_hit || (word_idx == LCD_CMD_IDX) ||
                    (word_idx == BLINK_CTRL_IDX) || (word_idx == CLK_CTRL_IDX);
  assign wr_acc   = psel && penable && pwrite;

  // Zero wait states; read data was captured during the setup cycle
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !reg_hit;
  assign prdata  = q.rdata;

  // ****************************************************************
  // Segment evaluation
  // ****************************************************************
  logic                blink_off; // In the blanking half of a blink period
  logic                whole_on;  // Every segment blinks
  logic [FP_COUNT-1:0] fp_next;   // Frontplane levels for this backplane

  // Phase bit chosen by the rate code: slower codes use higher bits
  assign blink_off = q.blk_en && q.bcnt[BLINK_BASE_BIT + 32'(q.rate)];
  assign whole_on  = q.whole && q.sel;

  // Each frontplane owns one nibble; the active backplane picks the bit
  for (genvar i = 0; i < FP_COUNT; i++)
  begin : g_fp
    logic seg_on;  // Display plane bit for this pair
    logic seg_blk; // Blink plane bit for this pair
    assign seg_on  = q.disp[i/2][(i%2)*4 + 32'(q.bp)];
    assign seg_blk = q.blink[i/2][(i%2)*4 + 32'(q.bp)];
    // With disp_en set, a set bit shows the segment unless the blink phase blanks it
    assign fp_next[i] = q.disp_en && seg_on &&
                        !(blink_off && (whole_on || seg_blk));
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Register writes, read capture and the timebase-paced scan
  always_comb
  begin
    d        = q;
    d.fstart = 1'b0;
    d.cptick = 1'b0;
    d.fp     = fp_next;

    // Capture read data in the setup cycle so prdata comes from a flop
    if (psel && !penable && !pwrite)
    begin
      d.rdata = 32'h0000_0000;
      if (seg_hit)
      begin
        // The select bit steers reads to one plane
        d.rdata[7:0] = q.sel ? q.blink[seg_byte] : q.disp[seg_byte];
      end
      else if (word_idx == LCD_CMD_IDX)
      begin
        d.rdata[CMD_SEL_BIT]               = q.sel;
        d.rdata[CMD_DISP_EN_BIT]           = q.disp_en;
        d.rdata[CMD_PHASE_BIT]             = !blink_off;
        d.rdata[CMD_BP_LSB +: 2]           = q.bp;
        d.rdata[CMD_STOP_BIT]              = deep_stop_mode;
      end
      else if (word_idx == BLINK_CTRL_IDX)
      begin
        d.rdata[BLK_EN_BIT]                = q.blk_en;
        d.rdata[BLK_WHOLE_BIT]             = q.whole;
        d.rdata[BLK_RATE_LSB +: 3]         = q.rate;
      end
      else if (word_idx == CLK_CTRL_IDX)
      begin
        d.rdata[CLK_SRC_BIT]               = q.src_ext;
        d.rdata[CLK_CP_LSB +: 2]           = q.cp_rate;
        d.rdata[CLK_DIV_LSB +: 16]         = q.ext_div;
      end
    end

    // Writes take effect at the access edge; unmapped writes are dropped
    if (wr_acc && seg_hit)
    begin
      if (q.sel)
      begin
        d.blink[seg_byte] = pwdata[7:0];
      end
      else
      begin
        d.disp[seg_byte] = pwdata[7:0];
      end
    end
    else if (wr_acc && (word_idx == LCD_CMD_IDX))
    begin
      d.sel     = pwdata[CMD_SEL_BIT];
      d.disp_en = pwdata[CMD_DISP_EN_BIT];
    end
    else if (wr_acc && (word_idx == BLINK_CTRL_IDX))
    begin
      d.blk_en = pwdata[BLK_EN_BIT];
      d.whole  = pwdata[BLK_WHOLE_BIT];
      d.rate   = pwdata[BLK_RATE_LSB +: 3];
    end
    else if (wr_acc && (word_idx == CLK_CTRL_IDX))
    begin
      d.src_ext = pwdata[CLK_SRC_BIT];
      d.cp_rate = pwdata[CLK_CP_LSB +: 2];
      d.ext_div = pwdata[CLK_DIV_LSB +: 16];
    end

    // Every slower rate is derived from the timebase tick alone
    if (tb_tick)
    begin
      d.bcnt  = q.bcnt + BLINK_CNT_W'(1);
      d.cpcnt = q.cpcnt + 4'h1;
      // Charge pump pulse every 2^(code+1) ticks
      if ((q.cpcnt & ((4'h2 << q.cp_rate) - 4'h1)) == ((4'h2 << q.cp_rate) - 4'h1))
      begin
        d.cptick = 1'b1;
      end
      // 128 ticks per backplane, four backplanes per 64 Hz frame
      if (q.phase == PHASE_LAST)
      begin
        d.phase = 7'h00;
        d.bp    = q.bp + 2'h1;
        if (q.bp == 2'(BP_COUNT - 1))
        begin
          d.fstart = 1'b1;
        end
      end
      else
      begin
        d.phase = q.phase + 7'h01;
      end
    end
  end

  // Register the whole state; control bits take their reset values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q         <= '0;
      q.sel     <= RST_SEL;
      q.disp_en <= RST_DISP_EN;
      q.blk_en  <= RST_BLK_EN;
      q.whole   <= RST_WHOLE;
      q.rate    <= RST_RATE;
      q.src_ext <= RST_SRC_EXT;
      q.cp_rate <= RST_CP_RATE;
      q.ext_div <= RST_EXT_DIV;
    end
    else
    begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign backplane_drive  = 4'h1 << q.bp;
  assign frontplane_drive = q.fp;
  assign frame_start      = q.fstart;
  assign charge_pump_tick = q.cptick;
  assign blink_phase_on   = !blink_off;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [12:0] gap_q;     // Cycles since the last timebase tick
  logic        gap_vld_q; // Last interval ran wholly on the internal path

  // Interval counter watched by the timebase checks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_q     <= 13'h0000;
      gap_vld_q <= 1'b0;
    end
    else
    begin
      gap_q     <= tb_tick ? 13'h0001 : gap_q + 13'h0001;
      gap_vld_q <= q.src_ext ? 1'b0 : (tb_tick ? 1'b1 : gap_vld_q);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tick_spacing: assert property (
    (tb_tick && gap_vld_q && !q.src_ext) |->
      (gap_q >= 13'(INT_TICK_MIN)) && (gap_q <= 13'(INT_TICK_MAX)))
    else $error("timebase tick spacing off 32.768 kHz");

  a_stop_keeps: assert property (
    (deep_stop_mode && gap_vld_q && !q.src_ext) |-> (gap_q <= 13'(INT_TICK_MAX)))
    else $error("timebase stalled in deep stop");

  a_scan_paced: assert property (
    (q.bp != $past(q.bp)) |-> $past(tb_tick) && ($past(q.phase) == PHASE_LAST))
    else $error("backplane moved without a timebase tick");

  a_frame_wrap: assert property (
    frame_start |-> (q.bp == 2'h0) && (q.phase == 7'h00) && $past(q.bp == 2'h3))
    else $error("frame start not after fourth backplane");

  a_blink_paced: assert property (
    (q.bcnt != $past(q.bcnt)) |-> $past(tb_tick))
    else $error("blink divider moved without a timebase tick");

  a_disp_write: assert property (
    (wr_acc && seg_hit && !q.sel) |=>
      (q.disp[$past(seg_byte)] == $past(pwdata[7:0])) && $stable(q.blink))
    else $error("display plane write lost");

  a_blink_write: assert property (
    (wr_acc && seg_hit && q.sel) |=>
      (q.blink[$past(seg_byte)] == $past(pwdata[7:0])) && $stable(q.disp))
    else $error("blink plane write lost");

  a_whole_blank: assert property (
    (blink_off && whole_on) |=> (frontplane_drive == '0))
    else $error("whole display blink did not blank");

  a_seg_blank: assert property (
    (!q.disp[0][q.bp]) |=> !frontplane_drive[0])
    else $error("cleared segment bit still driven");

  a_blink_show: assert property (
    (q.disp_en && q.disp[0][4 + 32'(q.bp)] && !blink_off) |=> frontplane_drive[1])
    else $error("segment hidden in blink on phase");

  a_pump_paced: assert property (
    charge_pump_tick |-> $past(tb_tick))
    else $error("charge pump pulse without a timebase tick");

  a_drive_off: assert property (
    (!q.disp_en) |=> (frontplane_drive == '0))
    else $error("frontplanes driven while display disabled");

  a_rd_disp: assert property (
    (psel && !penable && !pwrite && seg_hit && !q.sel) |=>
      (prdata[7:0] == $past(q.disp[seg_byte])))
    else $error("display plane read wrong");

  a_rd_blink: assert property (
    (psel && !penable && !pwrite && seg_hit && q.sel) |=>
      (prdata[7:0] == $past(q.blink[seg_byte])))
    else $error("blink plane read wrong");

endmodule : slb_lcd_top

//--- tb/slb_glass_model.sv
// Passive four by forty segment glass that records what each segment shows
`timescale 1ns/1ps

module slb_glass_model
  import slb_pkg::*;
(
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // Drive lines from the block
  input  wire logic [BP_COUNT-1:0]           backplane_drive,
  input  wire logic [FP_COUNT-1:0]           frontplane_drive,
  // What the glass shows, per backplane
  output logic      [BP_COUNT-1:0][FP_COUNT-1:0] lit,
  output logic                               bp_fault
);
  // ****************************************************************
  // Scan capture
  // ****************************************************************
  logic [BP_COUNT-1:0] bp_prev;  // Backplane seen one cycle before

  // Frontplanes lag a backplane step by one cycle, so skip that first cycle;
  // drive lines are unknown before the first reset edge, so hold the state cleared while reset is low
  always @(posedge pclk)
  begin
    if (!presetn)
    begin
      bp_prev  <= 4'h1;
      lit      <= '0;
      bp_fault <= 1'b0;
    end
    else
    begin
      bp_prev <= backplane_drive;
      if ($countones(backplane_drive) != 1)
        bp_fault <= 1'b1;
      else if (backplane_drive != bp_prev && backplane_drive != {bp_prev[2:0], bp_prev[3]})
        bp_fault <= 1'b1;
      for (int b = 0; b < BP_COUNT; b++)
        if (backplane_drive[b] && backplane_drive == bp_prev)
          lit[b] <= frontplane_drive;
    end
  end
endmodule : slb_glass_model

//--- tb/slb_lcd_top_tb.sv
// Self-checking bench for the segment LCD blink and timebase block
`timescale 1ns/1ps

`define CHK(g, x) \
  begin checks++; if ((g) !== (x)) begin miscompares++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, x); end end

module slb_lcd_top_tb;
  import slb_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                              pclk = 1'b0;
  logic                              presetn = 1'b0;
  logic                              psel = 1'b0;
  logic                              penable = 1'b0;
  logic                              pwrite = 1'b0;
  logic [15:0]                       paddr = 16'h0000;
  logic [31:0]                       pwdata = 32'h0000_0000;
  logic [31:0]                       prdata;
  logic                              pready;
  logic                              pslverr;
  logic                              ext_clk_src = 1'b0;
  logic                              ext_run = 1'b0;  // Toggle external source
  logic                              deep_stop_mode = 1'b0;
  logic [BP_COUNT-1:0]               backplane_drive;
  logic [FP_COUNT-1:0]               frontplane_drive;
  logic                              frame_start;
  logic                              charge_pump_tick;
  logic                              blink_phase_on;
  logic [BP_COUNT-1:0][FP_COUNT-1:0] lit;
  logic [BP_COUNT-1:0][FP_COUNT-1:0] exp_lit;  // Expected display picture
  logic                              bp_fault;
  int                                checks = 0;
  int                                miscompares = 0;

  // ****************************************************************
  // Clock, external source, instances
  // ****************************************************************
  always #2.5 pclk = ~pclk;
  // One rising source edge every two cycles keeps frames short
  always @(posedge pclk) if (ext_run) ext_clk_src <= ~ext_clk_src;

  slb_lcd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_src(ext_clk_src), .deep_stop_mode(deep_stop_mode),
    .backplane_drive(backplane_drive), .frontplane_drive(frontplane_drive),
    .frame_start(frame_start), .charge_pump_tick(charge_pump_tick),
    .blink_phase_on(blink_phase_on));

  slb_glass_model i_glass (.pclk(pclk), .presetn(presetn), .backplane_drive(backplane_drive),
    .frontplane_drive(frontplane_drive), .lit(lit), .bp_fault(bp_fault));

  // ****************************************************************
  // Bus and wait helpers
  // ****************************************************************
  // Setup then access, held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait limit here: only the watchdog may end a stalled transfer
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, i, d, r, e);
  endtask : wr

  // Read and compare data and error response
  task automatic rd(input logic [13:0] i, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, i, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask : rd

  function automatic logic ev(int s, logic p);
    return s == 0 ? frame_start === 1'b1 : s == 1 ? charge_pump_tick === 1'b1 : blink_phase_on !== p;
  endfunction : ev

  // Cycles between two events: frame, pump tick or blink phase change
  task automatic gap(input int s, output int n);
    logic p;
    p = blink_phase_on;
    do @(posedge pclk); while (!ev(s, p));
    p = blink_phase_on;
    n = 0;
    // Count every edge up to and including the one that sees the event
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!ev(s, p));
  endtask : gap

  task automatic frames;
    int n;
    gap(0, n);
  endtask : frames

  task automatic wait_phase(input logic v);
    while (blink_phase_on !== v) @(posedge pclk);
  endtask : wait_phase

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(LCD_CMD_IDX, 32'h0000_0010, 1'b0);
    rd(BLINK_CTRL_IDX, 32'h0, 1'b0);
    rd(CLK_CTRL_IDX, 32'h0, 1'b0);
    rd(SEG_BASE_IDX, 32'h0, 1'b0);
    rd(SEG_BASE_IDX + 14'd20, 32'h0, 1'b1);
    wr(SEG_BASE_IDX + 14'd20, 32'hff);
    rd(SEG_BASE_IDX + 14'd20, 32'h0, 1'b1);
  endtask : t_reset

  // Second plane is reached only while the select bit is set
  task automatic t_planes;
    wr(SEG_BASE_IDX, 32'ha5);
    wr(LCD_CMD_IDX, 32'h1);
    wr(SEG_BASE_IDX, 32'h3c);
    rd(SEG_BASE_IDX, 32'h3c, 1'b0);
    wr(LCD_CMD_IDX, 32'h0);
    rd(SEG_BASE_IDX, 32'ha5, 1'b0);
  endtask : t_planes

  task automatic t_display;
    logic [7:0] v;
    int         n;
    ext_run <= 1'b1;
    wr(CLK_CTRL_IDX, 32'hd);  // Slowest pump code for the glass
    for (int i = 0; i < SEG_BYTES; i++)
    begin
      v = 8'(i * 29 + 151);
      wr(SEG_BASE_IDX + 14'(i), {24'h0, v});
      for (int b = 0; b < BP_COUNT; b++)
      begin
        exp_lit[b][2*i]   = v[b];
        exp_lit[b][2*i+1] = v[4+b];
      end
    end
    `CHK(frontplane_drive, 40'h0)
    wr(LCD_CMD_IDX, 32'h2);
    frames();
    frames();
    `CHK(lit, exp_lit)
    gap(0, n);
    `CHK(n, 1024)
    gap(1, n);
    `CHK(n, 32)
    wr(CLK_CTRL_IDX, 32'h1_000d);
    gap(0, n);
    gap(0, n);
    `CHK(n, 2048)
    wr(CLK_CTRL_IDX, 32'hd);
  endtask : t_display

  task automatic t_blink;
    logic [31:0] r;
    logic        e;
    int          n;
    deep_stop_mode <= 1'b1;
    wr(LCD_CMD_IDX, 32'h3);
    wr(SEG_BASE_IDX, 32'h01);
    apb(1'b0, LCD_CMD_IDX, 32'h0, r, e);
    `CHK(r[CMD_STOP_BIT], 1'b1)
    wr(BLINK_CTRL_IDX, 32'h1);
    gap(2, n);
    `CHK(n, 4096)
    wait_phase(1'b0);
    frames();
    frames();
    `CHK(lit, exp_lit & ~160'h1)
    wr(BLINK_CTRL_IDX, 32'h3);
    wait_phase(1'b1);
    wait_phase(1'b0);
    frames();
    frames();
    `CHK(lit, 160'h0)
    wait_phase(1'b1);
    frames();
    frames();
    `CHK(lit, exp_lit)
    wr(BLINK_CTRL_IDX, 32'h5);
    gap(2, n);
    `CHK(n, 8192)
    wr(BLINK_CTRL_IDX, 32'h0);
  endtask : t_blink

  // Internal source: two timebase ticks per pump tick at code zero
  task automatic t_internal;
    int n;
    ext_run <= 1'b0;
    wr(CLK_CTRL_IDX, 32'h0);
    gap(1, n);
    `CHK(n >= 2 * INT_TICK_MIN && n <= 2 * INT_TICK_MAX, 1'b1)
    `CHK(bp_fault, 1'b0)
  endtask : t_internal

  // ****************************************************************
  // Verdict, watchdog, main sequence
  // ****************************************************************
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial
  begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    results();
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(backplane_drive, 4'h1)
    `CHK(blink_phase_on, 1'b1)
    t_reset();
    t_planes();
    t_display();
    t_blink();
    t_internal();
    results();
  end
endmodule : slb_lcd_top_tb
